// ---- verilog/mode_trap_pkg.sv ----
// Package of constants for the mode, trap and extended move execution block
package mode_trap_pkg;
    localparam int ADDR_W = 19;
    localparam int CHAR_W = 9;
    localparam int BANK_W = 12;
    localparam int SECTOR_W = 15;
    localparam logic [1:0] ADDR_MODE_2 = 2'h0;
    localparam logic [1:0] ADDR_MODE_3 = 2'h1;
    localparam logic [1:0] ADDR_MODE_4 = 2'h2;
    localparam logic [5:0] VAR_MODE_4_TRAP_S = 6'h3c;
    localparam int VAR_TRAP_BIT = 2;
    localparam int VAR_S_BIT = 3;
    localparam int VAR_SIZE_LO = 4;
    localparam int CH_DATA_LO = 0;
    localparam int CH_WM_BIT = 6;
    localparam int CH_IM_BIT = 7;
    localparam int CH_RM_BIT = 8;
    localparam logic [5:0] DATA_MASK = 6'h3f;
    localparam logic [2:0] DIR_DEC_ONE = 3'h0;
    localparam logic [2:0] DIR_INC_ONE = 3'h1;
    localparam logic [2:0] STOP_WM_RL = 3'h2;
    localparam logic [2:0] STOP_WM_LR = 3'h3;
    localparam logic [2:0] STOP_IM_RL = 3'h4;
    localparam logic [2:0] STOP_IM_LR = 3'h5;
    localparam logic [2:0] STOP_RM_RL = 3'h6;
    localparam logic [2:0] STOP_RM_LR = 3'h7;
    localparam logic [5:0] OP_MODE_CHANGE = 6'h01;
    localparam logic [5:0] OP_SEQ_SWAP = 6'h02;
    localparam logic [5:0] OP_EXT_MOVE = 6'h03;
    localparam logic [1:0] FMT_A = 2'h0;
    localparam logic [1:0] FMT_B = 2'h1;
    localparam logic [1:0] FMT_C = 2'h2;
    localparam logic [1:0] FMT_D = 2'h3;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 19'h0_0001;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 19'h0_0000;
endpackage : mode_trap_pkg

// ---- verilog/mem_port_if.sv ----
// Interface carrying the character memory port between merge unit and executor
`timescale 1ns/1ps
`default_nettype none
interface mem_port_if;
    import mode_trap_pkg::*;
    logic [CHAR_W-1:0] src_char;
    logic [CHAR_W-1:0] dst_char;
    logic [2:0]        sel;
    logic [CHAR_W-1:0] merged;
    modport exec (output src_char, output dst_char, output sel, input merged);
    modport merge (input src_char, input dst_char, input sel, output merged);
endinterface : mem_port_if
`default_nettype wire

// ---- verilog/char_merge.sv ----
// Bit-class selective merge of a source character into a destination character
`timescale 1ns/1ps
`default_nettype none
module char_merge
    import mode_trap_pkg::*;
(
    mem_port_if.merge mp
);
    wire logic [5:0] data_bits;
    wire logic       wm_bit;
    wire logic       im_bit;
    wire logic       rm_bit;
    // Unselected classes keep the destination bits
    assign data_bits = mp.sel[0] ? mp.src_char[5:0] : mp.dst_char[5:0];
    assign wm_bit    = mp.sel[1] ? mp.src_char[CH_WM_BIT] : mp.dst_char[CH_WM_BIT];
    assign im_bit    = mp.sel[2] ? mp.src_char[CH_IM_BIT] : mp.dst_char[CH_IM_BIT];
    // Record mark travels with the item-mark class
    assign rm_bit    = mp.sel[2] ? mp.src_char[CH_RM_BIT] : mp.dst_char[CH_RM_BIT];
    assign mp.merged = {rm_bit, im_bit, wm_bit, data_bits};
endmodule : char_merge
`default_nettype wire

// ---- verilog/mode_trap_exec.sv ----
// Execution logic for mode change, sequence swap and extended move instructions
//
// The plain strobed memory port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module mode_trap_exec
    import mode_trap_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              instr_valid,
    input  wire logic [5:0]        instr_op,
    input  wire logic              instr_op_im,
    input  wire logic              instr_op_rm,
    input  wire logic [1:0]        instr_fmt,
    input  wire logic [ADDR_W-1:0] instr_a_field,
    input  wire logic [ADDR_W-1:0] instr_b_field,
    input  wire logic [5:0]        instr_variant,
    input  wire logic [ADDR_W-1:0] instr_next_addr,
    output logic                   instr_ready,
    output logic                   instr_other,
    output logic [1:0]             addr_mode,
    output logic                   trap_mode,
    output logic                   special_mode,
    output logic [ADDR_W-1:0]      seq_ptr,
    output logic [ADDR_W-1:0]      alt_seq_ptr,
    output logic [ADDR_W-1:0]      a_reg,
    output logic [ADDR_W-1:0]      b_reg,
    output logic [5:0]             var_reg,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic                   mem_rd,
    output logic                   mem_wr,
    output logic [CHAR_W-1:0]      mem_wdata,
    input  wire logic [CHAR_W-1:0] mem_rdata,
    output logic                   busy
);
    typedef enum logic [4:0] {
        S_IDLE  = 5'b0_0001,
        S_RDSRC = 5'b0_0010,
        S_RDDST = 5'b0_0100,
        S_WRITE = 5'b0_1000,
        S_STEP  = 5'b1_0000
    } state_e;

    state_e            state_q, state_d;
    logic [1:0]        mode_q;
    logic              trap_q;
    logic              spec_q;
    logic [ADDR_W-1:0] sr_q, csr_q, aar_q, bar_q;
    logic [5:0]        var_q;
    logic [CHAR_W-1:0] src_q, dst_q;
    logic              last_q;

    mem_port_if mp ();

    char_merge u_merge (
        .mp (mp)
    );

    // Width limit of an address field under a given mode, merged with the held base
    function automatic logic [ADDR_W-1:0] resolve_addr(
        input logic [1:0]        mode,
        input logic [ADDR_W-1:0] field,
        input logic [ADDR_W-1:0] base
    );
        logic [ADDR_W-1:0] r;
        r = field;
        unique case (mode)
            ADDR_MODE_2: r = {base[ADDR_W-1:BANK_W], field[BANK_W-1:0]};
            ADDR_MODE_3: r = {base[ADDR_W-1:SECTOR_W], field[SECTOR_W-1:0]};
            default:     r = field;
        endcase
        return r;
    endfunction : resolve_addr

    // Variant bits 5 and 4 pick the size; 00 and 40 both mean three characters
    // Trap and special bits never change the size, so bit 3 is not looked at here
    function automatic logic [1:0] mode_of_variant(input logic [5:0] v);
        logic [1:0] m;
        m = ADDR_MODE_3;
        unique case (v[5:4])
            2'h1:    m = ADDR_MODE_2;
            2'h3:    m = ADDR_MODE_4;
            default: m = ADDR_MODE_3;
        endcase
        return m;
    endfunction : mode_of_variant

    wire logic              trapped;
    wire logic              is_mode;
    wire logic              is_swap;
    wire logic              is_move;
    wire logic              accept;
    wire logic [ADDR_W-1:0] a_res;
    wire logic [ADDR_W-1:0] b_res;
    wire logic [5:0]        var_eff;
    wire logic [ADDR_W-1:0] a_src;
    wire logic [ADDR_W-1:0] b_dst;
    wire logic [2:0]        mv_hi;
    wire logic              mv_inc;
    wire logic              mv_single;
    wire logic              stop_hit;

    assign trapped   = trap_q && (instr_op_im || instr_op_rm);
    assign is_swap   = trapped || (instr_op == OP_SEQ_SWAP);
    assign is_mode   = !trapped && (instr_op == OP_MODE_CHANGE);
    assign is_move   = !trapped && (instr_op == OP_EXT_MOVE);
    assign accept    = instr_valid && (state_q == S_IDLE);
    assign a_res     = resolve_addr(mode_q, instr_a_field, aar_q);
    assign b_res     = resolve_addr(mode_q, instr_b_field, bar_q);
    // Formats: a full, b keep variant, c keep B too, d keep A as well
    assign var_eff   = (instr_fmt == FMT_A) ? instr_variant : var_q;
    assign b_dst     = (instr_fmt == FMT_C || instr_fmt == FMT_D) ? bar_q : b_res;
    assign a_src     = (instr_fmt == FMT_D) ? aar_q : a_res;
    assign mv_hi     = var_q[5:3];
    assign mv_inc    = mv_hi[0];
    assign mv_single = (mv_hi == DIR_DEC_ONE) || (mv_hi == DIR_INC_ONE);
    assign stop_hit  = ((mv_hi == STOP_WM_RL || mv_hi == STOP_WM_LR) && src_q[CH_WM_BIT])
                    || ((mv_hi == STOP_IM_RL || mv_hi == STOP_IM_LR) && src_q[CH_IM_BIT])
                    || ((mv_hi == STOP_RM_RL || mv_hi == STOP_RM_LR) && src_q[CH_RM_BIT]);

    assign mp.src_char = src_q;
    assign mp.dst_char = dst_q;
    assign mp.sel      = var_q[2:0];

    // Move sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE:  if (accept && is_move) state_d = S_RDSRC;
            S_RDSRC: state_d = S_RDDST;
            S_RDDST: state_d = S_WRITE;
            S_WRITE: state_d = S_STEP;
            S_STEP:  state_d = last_q ? S_IDLE : S_RDSRC;
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Mode flags from mode change
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= ADDR_MODE_3;
            trap_q <= 1'b0;
            spec_q <= 1'b0;
        end else if (accept && is_mode) begin
            mode_q <= mode_of_variant(var_eff);
            trap_q <= var_eff[VAR_TRAP_BIT];
            spec_q <= var_eff[VAR_S_BIT];
        end
    end

    // Sequence and alternate pointers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sr_q  <= ADDR_ZERO;
            csr_q <= ADDR_ZERO;
        end else if (accept && is_swap) begin
            sr_q  <= csr_q;
            csr_q <= instr_next_addr;
        end else if (accept) begin
            sr_q  <= instr_next_addr;
        end
    end

    // Operand and variant registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aar_q <= ADDR_ZERO;
            bar_q <= ADDR_ZERO;
            var_q <= 6'h00;
        end else if (accept && is_swap) begin
            if (instr_fmt != FMT_A) aar_q <= a_res;
            if (instr_fmt == FMT_C || instr_fmt == FMT_D) bar_q <= b_res;
            if (instr_fmt == FMT_D) var_q <= instr_variant;
        end else if (accept && is_move) begin
            aar_q <= a_src;
            bar_q <= b_dst;
            var_q <= var_eff;
        end else if (accept && is_mode && instr_fmt == FMT_A) begin
            var_q <= instr_variant;
        end else if (state_q == S_STEP) begin
            aar_q <= mv_inc ? aar_q + ADDR_ONE : aar_q - ADDR_ONE;
            bar_q <= mv_inc ? bar_q + ADDR_ONE : bar_q - ADDR_ONE;
        end
    end

    // Character capture and stop detection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            src_q  <= 9'h000;
            dst_q  <= 9'h000;
            last_q <= 1'b0;
        end else begin
            if (state_q == S_RDDST) src_q <= mem_rdata;
            if (state_q == S_WRITE) dst_q <= mem_rdata;
            if (state_q == S_WRITE) last_q <= mv_single || stop_hit;
        end
    end

    // Memory port: read issued one cycle before data is captured
    assign mem_rd      = (state_q == S_RDSRC) || (state_q == S_RDDST);
    assign mem_wr      = (state_q == S_STEP);
    assign mem_addr    = (state_q == S_RDSRC) ? aar_q : bar_q;
    assign mem_wdata   = mp.merged;
    assign instr_ready = (state_q == S_IDLE);
    assign instr_other = accept && !is_swap && !is_mode && !is_move;
    assign busy        = (state_q != S_IDLE);
    assign addr_mode    = mode_q;
    assign trap_mode    = trap_q;
    assign special_mode = spec_q;
    assign seq_ptr      = sr_q;
    assign alt_seq_ptr  = csr_q;
    assign a_reg        = aar_q;
    assign b_reg        = bar_q;
    assign var_reg      = var_q;
endmodule : mode_trap_exec
`default_nettype wire

// ---- tb/char_mem.sv ----
// Behavioural character memory answering a read in the following cycle
`timescale 1ns/1ps
`default_nettype none
module char_mem
    import mode_trap_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic              mem_rd,
    input  wire logic              mem_wr,
    input  wire logic [CHAR_W-1:0] mem_wdata,
    output logic      [CHAR_W-1:0] mem_rdata
);
    logic [CHAR_W-1:0] mem [0:255];
    initial mem_rdata = 9'h000;
    always @(posedge clk) begin
        if (mem_wr) mem[mem_addr[7:0]] <= mem_wdata;
        // Outside a read the data inverts, so stale values never pass for real ones
        mem_rdata <= mem_rd ? mem[mem_addr[7:0]] : ~mem_rdata;
    end
endmodule : char_mem
`default_nettype wire

// ---- tb/mode_trap_exec_asserts.sv ----
// Concurrent checks on the ports of the execution block
`timescale 1ns/1ps
`default_nettype none
module mode_trap_exec_asserts
    import mode_trap_pkg::*;
(
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              instr_valid,
    input wire logic [5:0]        instr_op,
    input wire logic              instr_op_im,
    input wire logic              instr_op_rm,
    input wire logic [1:0]        instr_fmt,
    input wire logic [ADDR_W-1:0] instr_a_field,
    input wire logic [5:0]        instr_variant,
    input wire logic [ADDR_W-1:0] instr_next_addr,
    input wire logic              instr_ready,
    input wire logic              instr_other,
    input wire logic [1:0]        addr_mode,
    input wire logic              trap_mode,
    input wire logic              special_mode,
    input wire logic [ADDR_W-1:0] seq_ptr,
    input wire logic [ADDR_W-1:0] alt_seq_ptr,
    input wire logic [ADDR_W-1:0] a_reg,
    input wire logic [ADDR_W-1:0] b_reg,
    input wire logic [5:0]        var_reg,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic              mem_wr,
    input wire logic [CHAR_W-1:0] mem_wdata,
    input wire logic [CHAR_W-1:0] mem_rdata
);
    wire take = instr_valid && instr_ready;
    wire trp  = take && trap_mode && (instr_op_im || instr_op_rm);
    wire swp  = trp || (take && instr_op == OP_SEQ_SWAP);
    wire chg  = take && !trp && instr_op == OP_MODE_CHANGE && instr_fmt == FMT_A;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_mode_four_trap: assert property (chg && instr_variant == VAR_MODE_4_TRAP_S
        |=> addr_mode == ADDR_MODE_4 && trap_mode && special_mode) else $error("mode 74 wrong");
    a_mode_size: assert property (chg |=> addr_mode ==
        ($past(instr_variant[5:4]) == 2'h1 ? ADDR_MODE_2 :
        ($past(instr_variant[5:4]) == 2'h3 ? ADDR_MODE_4 : ADDR_MODE_3))) else $error("size wrong");
    a_mode_flags: assert property (chg |=> trap_mode == $past(instr_variant[VAR_TRAP_BIT])
        && special_mode == $past(instr_variant[VAR_S_BIT])) else $error("mode flags wrong");
    a_swap_pointers: assert property (swp |=> seq_ptr == $past(alt_seq_ptr)
        && alt_seq_ptr == $past(instr_next_addr)) else $error("pointer swap wrong");
    a_trap_not_other: assert property (trp |-> !instr_other)
        else $error("trapped op executed");
    a_swap_bank_keep: assert property (swp && instr_fmt == FMT_B && addr_mode == ADDR_MODE_2
        |=> a_reg == {$past(a_reg[ADDR_W-1:BANK_W]), $past(instr_a_field[BANK_W-1:0])})
        else $error("bank bits lost");
    a_merge_data: assert property (mem_wr |-> mem_wdata[5:0] ==
        (var_reg[0] ? $past(mem_rdata[5:0], 2) : $past(mem_rdata[5:0]))) else $error("merge wrong");
    a_move_step: assert property (mem_wr && addr_mode == ADDR_MODE_4 |-> mem_addr == b_reg
        ##1 b_reg == (var_reg[3] ? $past(b_reg) + ADDR_ONE : $past(b_reg) - ADDR_ONE))
        else $error("step wrong");
endmodule : mode_trap_exec_asserts
bind mode_trap_exec mode_trap_exec_asserts i_mode_trap_exec_asserts (.clk, .rstn, .instr_valid,
    .instr_op, .instr_op_im, .instr_op_rm, .instr_fmt, .instr_a_field, .instr_variant,
    .instr_next_addr, .instr_ready, .instr_other, .addr_mode, .trap_mode, .special_mode,
    .seq_ptr, .alt_seq_ptr, .a_reg, .b_reg, .var_reg, .mem_addr, .mem_wr, .mem_wdata, .mem_rdata);
`default_nettype wire

// ---- tb/mode_trap_exec_tb.sv ----
// Self-checking bench for the mode, trap and extended move block
`timescale 1ns/1ps
`default_nettype none
module mode_trap_exec_tb;
    import mode_trap_pkg::*;
    logic              clk = 1'b0, rstn = 1'b0, instr_valid = 1'b0;
    logic [5:0]        instr_op = 6'h00, instr_variant = 6'h00, var_reg;
    logic [1:0]        mk = 2'h0, instr_fmt = 2'h0, addr_mode;
    logic [ADDR_W-1:0] instr_a_field = '0, instr_b_field = '0, instr_next_addr = '0;
    logic [ADDR_W-1:0] seq_ptr, alt_seq_ptr, a_reg, b_reg, mem_addr;
    logic              instr_ready, instr_other, trap_mode, special_mode, mem_rd, mem_wr, busy;
    logic              other_seen = 1'b0;
    logic [CHAR_W-1:0] mem_wdata, mem_rdata;
    logic [CHAR_W-1:0] src [4] = '{9'h001, 9'h102, 9'h043, 9'h047};
    logic [5:0]        vt [13] = '{6'h10, 6'h00, 6'h20, 6'h30, 6'h14, 6'h04, 6'h34,
                                   6'h18, 6'h08, 6'h38, 6'h1c, 6'h0c, 6'h3c};
    int                err_total = 0, n_tests = 0, i;
    mode_trap_exec i_mode_trap_exec (.clk, .rstn, .instr_valid, .instr_op, .instr_op_im(mk[0]),
        .instr_op_rm(mk[1]), .instr_fmt, .instr_a_field, .instr_b_field, .instr_variant,
        .instr_next_addr, .instr_ready, .instr_other, .addr_mode, .trap_mode, .special_mode,
        .seq_ptr, .alt_seq_ptr, .a_reg, .b_reg, .var_reg, .mem_addr, .mem_rd, .mem_wr,
        .mem_wdata, .mem_rdata, .busy);
    char_mem i_char_mem (.clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
    initial forever #4 clk = ~clk;
    task automatic chk(input string nm, input logic [ADDR_W-1:0] e, input logic [ADDR_W-1:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic issue(input logic [5:0] op, input logic [1:0] m, input logic [1:0] f,
        input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b, input logic [5:0] v,
        input logic [ADDR_W-1:0] n);
        int k;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        mk <= m;
        instr_fmt <= f;
        instr_a_field <= a;
        instr_b_field <= b;
        instr_variant <= v;
        instr_next_addr <= n;
        // The other-op flag only stands in the cycle the instruction is taken
        #1;
        other_seen = instr_other;
        @(posedge clk);
        instr_valid <= 1'b0;
        k = 0;
        #1;
        // Moves hold the block busy; the bound catches a move that never stops
        while (busy !== 1'b0 && k < 400) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk("busy", '0, busy);
    endtask : issue
    task automatic finish_test;
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("addr_mode", ADDR_MODE_3, addr_mode);
        for (i = 0; i < 13; i++) begin
            issue(OP_MODE_CHANGE, 2'h0, FMT_A, '0, '0, vt[i], '0);
            chk("addr_mode", vt[i][5:4] == 2'h1 ? ADDR_MODE_2 :
                (vt[i][5:4] == 2'h3 ? ADDR_MODE_4 : ADDR_MODE_3), addr_mode);
            chk("trap_mode", vt[i][2], trap_mode);
            chk("special_mode", vt[i][3], special_mode);
        end
        issue(OP_SEQ_SWAP, 2'h0, FMT_D, 19'h7_1234, 19'h5_4321, 6'h2a, 19'h0_0100);
        chk("seq_ptr", '0, seq_ptr);
        chk("alt_seq_ptr", 19'h0_0100, alt_seq_ptr);
        chk("var_reg", 6'h2a, var_reg);
        issue(OP_SEQ_SWAP, 2'h0, FMT_B, 19'h2_2222, 19'h1_1111, 6'h01, 19'h0_0200);
        chk("a_reg", 19'h2_2222, a_reg);
        chk("b_reg", 19'h5_4321, b_reg);
        issue(6'h15, 2'h1, FMT_C, 19'h3_0003, 19'h3_0004, 6'h01, 19'h0_0300);
        chk("seq_ptr", 19'h0_0200, seq_ptr);
        chk("b_reg", 19'h3_0004, b_reg);
        chk("instr_other", 1'b0, other_seen);
        issue(6'h15, 2'h0, FMT_A, '0, '0, 6'h01, 19'h0_0350);
        chk("instr_other", 1'b1, other_seen);
        chk("seq_ptr", 19'h0_0350, seq_ptr);
        issue(OP_EXT_MOVE, 2'h2, FMT_A, '0, '0, 6'h01, 19'h0_0400);
        chk("seq_ptr", 19'h0_0300, seq_ptr);
        issue(OP_MODE_CHANGE, 2'h0, FMT_A, '0, '0, 6'h10, '0);
        issue(OP_SEQ_SWAP, 2'h0, FMT_B, 19'h7_0abc, '0, 6'h01, 19'h0_0500);
        chk("a_reg", 19'h3_0abc, a_reg);
        issue(OP_MODE_CHANGE, 2'h0, FMT_A, '0, '0, 6'h30, '0);
        i_char_mem.mem[16] = 9'h06a;
        i_char_mem.mem[32] = 9'h095;
        issue(OP_EXT_MOVE, 2'h0, FMT_A, 19'h0_0010, 19'h0_0020, 6'h09, '0);
        chk("dst", 9'h0aa, i_char_mem.mem[32]);
        chk("a_reg", 19'h0_0011, a_reg);
        for (i = 0; i < 4; i++) begin
            i_char_mem.mem[64 + i] = src[i];
            i_char_mem.mem[80 + i] = 9'h080;
        end
        i_char_mem.mem[84] = 9'h1ff;
        issue(OP_EXT_MOVE, 2'h0, FMT_A, 19'h0_0040, 19'h0_0050, 6'h1b, '0);
        chk("a_reg", 19'h0_0043, a_reg);
        issue(OP_EXT_MOVE, 2'h0, FMT_D, '0, '0, 6'h00, '0);
        chk("b_reg", 19'h0_0054, b_reg);
        for (i = 0; i < 4; i++) begin
            chk("dst", {2'h1, src[i][6:0]}, i_char_mem.mem[80 + i]);
        end
        chk("dst_stop", 9'h1ff, i_char_mem.mem[84]);
        i_char_mem.mem[96] = 9'h0a2;
        i_char_mem.mem[97] = 9'h021;
        i_char_mem.mem[111] = 9'h1ff;
        i_char_mem.mem[112] = 9'h040;
        i_char_mem.mem[113] = 9'h040;
        issue(OP_EXT_MOVE, 2'h0, FMT_A, 19'h0_0061, 19'h0_0071, 6'h25, '0);
        chk("dst_hi", 9'h061, i_char_mem.mem[113]);
        chk("dst_lo", 9'h0e2, i_char_mem.mem[112]);
        chk("dst_stop", 9'h1ff, i_char_mem.mem[111]);
        chk("a_reg", 19'h0_005f, a_reg);
        finish_test();
    end
endmodule : mode_trap_exec_tb
`default_nettype wire
